// [hw/safc_frame_ctrl.sv]
// Conversion frame, mode and serial readout control of the converter
// Notes on behaviour
// - Select fall starts conversion, drives output
// - Sample held at select fall
// - Clock edges counted from select fall
// - Back to track on 13th rise
// - Output released after 16th fall or select rise
// - Sixteen cycles, bits launched on falls
// - Four zeros then twelve bits, MSB first
// - Result is straight binary, 4096 codes
// - First conversion after wake is dummy
// - Unknown mode at start, dummy first
// - Rise between 2nd and 10th: shutdown
// - Rise before 2nd fall keeps mode
// - Rise after 10th: normal, word truncated
// - Stay low past 10th to leave shutdown
`timescale 1ns/100ps
module safc_frame_ctrl
   import safc_pkg::*;
#(
   parameter int DW = DATA_BITS
)(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          conv_sel_n,
   input  wire logic          serial_clk,
   input  wire logic [DW-1:0] conv_result,
   output logic               result_serial_out,
   output logic               result_oe_n,
   output logic               hold_mode,
   output logic               normal_mode,
   output logic               result_invalid,
   output logic               acq_short
);

   // Widths the logic cannot serve stop elaboration
   if (DW != DATA_BITS) $error("safc_frame_ctrl: DW must equal 12");
   if (ACQ_CYCLES >= (1 << ACQ_W)) $error("safc_frame_ctrl: ACQ_W small");

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and edge detection
   logic cs_s, sclk_s, cs_d, sclk_d;
   logic cs_fall, cs_rise, sclk_fall, sclk_rise;

   safc_sync #(
      .W        (2)
   ) u_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({conv_sel_n, serial_clk}),
      .sync_out ({cs_s, sclk_s})
   );

   // Delayed levels; reset high so no false edge follows release
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cs_d   <= 1'b1;
         sclk_d <= 1'b1;
      end else begin
         cs_d   <= cs_s;
         sclk_d <= sclk_s;
      end
   end

   assign cs_fall   = cs_d & ~cs_s;
   assign cs_rise   = ~cs_d & cs_s;
   assign sclk_fall = sclk_d & ~sclk_s;
   assign sclk_rise = ~sclk_d & sclk_s;

   ////////////////////////////////////////////////////////////////////////
   // Frame sequencer and edge counters
   safc_state_t      state;
   logic [CNT_W-1:0] fall_cnt;
   logic [CNT_W-1:0] rise_cnt;
   logic             in_frame, last_fall;

   assign in_frame  = (state == SAFC_FRAME);
   assign last_fall = in_frame & sclk_fall & (fall_cnt == FALL_LAST - 5'h01);

   // Frame runs from select fall to 16th fall or select rise
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= SAFC_IDLE;
      end else begin
         unique case (state)
            SAFC_IDLE: begin
               if (cs_fall) state <= SAFC_FRAME;
            end
            SAFC_FRAME: begin
               if (cs_rise) state <= SAFC_IDLE;
               else if (last_fall) state <= SAFC_DONE;
            end
            SAFC_DONE: begin
               // Select idled low must go high before the next frame
               if (cs_rise) state <= SAFC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fall_cnt <= '0;
      end else if (cs_fall) begin
         fall_cnt <= '0;
      end else if (in_frame && sclk_fall) begin
         fall_cnt <= fall_cnt + 5'h01;
      end
   end

   // Rising edges only matter up to the 13th
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rise_cnt <= '0;
      end else if (cs_fall) begin
         rise_cnt <= '0;
      end else if (in_frame && sclk_rise && rise_cnt < RISE_TRACK) begin
         rise_cnt <= rise_cnt + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Track and hold
   logic track_start;
   assign track_start = in_frame & sclk_rise & rise_cnt == RISE_TRACK - 5'h01;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hold_mode <= RESET_HOLD;
      end else if (cs_fall) begin
         hold_mode <= 1'b1;
      end else if (track_start || cs_rise) begin
         hold_mode <= 1'b0;   // an aborted conversion also tracks again
      end
   end

   // Acquisition timer; the host owns this interval, we only report it
   logic [ACQ_W-1:0] acq_cnt;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acq_cnt <= ACQ_W'(ACQ_CYCLES);
      end else if (track_start) begin
         acq_cnt <= ACQ_W'(1);   // the edge itself counts as one cycle
      end else if (acq_cnt < ACQ_W'(ACQ_CYCLES)) begin
         acq_cnt <= acq_cnt + 6'h01;
      end
   end

   // flag a frame that started too soon after the last 13th rise
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acq_short <= 1'b0;
      end else if (cs_fall) begin
         acq_short <= (acq_cnt < ACQ_W'(ACQ_CYCLES));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial result output
   logic [WORD_BITS-1:0] frame_word;

   assign frame_word = {{ZERO_BITS{1'b0}}, conv_result};

   safc_shifter #(
      .W         (WORD_BITS)
   ) u_shift (
      .clk       (clk),
      .rst_n     (rst_n),
      .load      (cs_fall),
      .load_word (frame_word),
      .shift     (in_frame & sclk_fall),
      .bit_out   (result_serial_out)
   );

   // release on 16th fall or select rise
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         result_oe_n <= RESET_OE_N;
      end else if (cs_fall) begin
         result_oe_n <= 1'b0;
      end else if (last_fall || cs_rise) begin
         result_oe_n <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Operating mode and dummy conversion
   logic first_conv;

   // normal only once select stays low past 10th fall
   // very early rise leaves mode alone
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         normal_mode <= RESET_NORMAL;
      end else if (in_frame && sclk_fall && !cs_rise
                   && fall_cnt == FALL_MODE - 5'h01) begin
         normal_mode <= 1'b1;   // an abort in the same cycle wins
      end else if (in_frame && cs_rise && fall_cnt >= FALL_NOISE
                   && fall_cnt < FALL_MODE) begin
         normal_mode <= 1'b0;
      end
   end

   // mode unknown after reset, so the first frame is a dummy
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         first_conv <= 1'b1;
      end else if (cs_fall) begin
         first_conv <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         result_invalid <= 1'b1;
      end else if (cs_fall) begin
         result_invalid <= first_conv | ~normal_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic [DW-1:0] cap_result;
   logic          step;   // serial fall in a frame, no abort beside it
   assign step = in_frame & sclk_fall & ~cs_rise;

   // Helper copy of the value held at the select fall
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cap_result <= '0;
      end else if (cs_fall) begin
         cap_result <= conv_result;
      end
   end

   property p_fall_drives;
      cs_fall |=> !result_oe_n && !result_serial_out;
   endproperty
   a_fall_drives: assert property (p_fall_drives)
      else $error("output not driven after select fall");
   property p_fall_holds;
      cs_fall |=> hold_mode;
   endproperty
   a_fall_holds: assert property (p_fall_holds)
      else $error("no hold after select fall");
   property p_count;
      step |=> fall_cnt == 5'($past(fall_cnt) + 1);
   endproperty
   a_count: assert property (p_count)
      else $error("falling edge count wrong");
   property p_track13;
      in_frame && sclk_rise && rise_cnt == 5'h0c |=> !hold_mode;
   endproperty
   a_track13: assert property (p_track13)
      else $error("hold not released on 13th rise");
   property p_hold_early;
      hold_mode && rise_cnt < 5'h0c && !cs_rise |=> hold_mode;
   endproperty
   a_hold_early: assert property (p_hold_early)
      else $error("hold released too early");
   property p_release16;
      in_frame && sclk_fall && fall_cnt == 5'h0f |=> result_oe_n;
   endproperty
   a_release16: assert property (p_release16)
      else $error("output not released after 16th fall");
   property p_release_cs;
      cs_rise |=> result_oe_n ##1 result_oe_n;
   endproperty
   a_release_cs: assert property (p_release_cs)
      else $error("output not released on select rise");
   property p_drive_mid;
      step && fall_cnt < 5'h0f |=> !result_oe_n;
   endproperty
   a_drive_mid: assert property (p_drive_mid)
      else $error("output dropped mid-word");
   property p_msb_fourth;
      step && fall_cnt == 5'h03 |=> result_serial_out == cap_result[DW-1];
   endproperty
   a_msb_fourth: assert property (p_msb_fourth)
      else $error("data MSB not after leading zeros");
   property p_lsb_last;
      step && fall_cnt == 5'h0e |=> result_serial_out == cap_result[0];
   endproperty
   a_lsb_last: assert property (p_lsb_last)
      else $error("data LSB not in last slot");
   property p_dummy;
      cs_fall && !normal_mode |=> result_invalid;
   endproperty
   a_dummy: assert property (p_dummy)
      else $error("wake-up frame not marked dummy");
   property p_shutdown;
      in_frame && cs_rise && fall_cnt inside {[5'h02:5'h09]} |=> !normal_mode;
   endproperty
   a_shutdown: assert property (p_shutdown)
      else $error("shutdown not entered");
   property p_keep;
      in_frame && cs_rise && fall_cnt < 5'h02 |=> $stable(normal_mode);
   endproperty
   a_keep: assert property (p_keep)
      else $error("mode changed by very early rise");
   property p_keep_normal;
      cs_rise && fall_cnt >= 5'h0a |=> normal_mode;
   endproperty
   a_keep_normal: assert property (p_keep_normal)
      else $error("normal mode lost after 10th fall");
   property p_wake;
      step && fall_cnt == 5'h09 |=> normal_mode;
   endproperty
   a_wake: assert property (p_wake)
      else $error("normal mode not reached at 10th fall");

   c_full_frame: cover property (last_fall);
   c_shutdown:   cover property (cs_rise && fall_cnt == 5'h05 && in_frame);
   c_truncate:   cover property (cs_rise && fall_cnt == 5'h0c && in_frame);
   c_wake:       cover property (cs_fall && !normal_mode ##[1:400] last_fall);

endmodule

// [hw/safc_pkg.sv]
// Shared constants for the serial converter frame control block
package safc_pkg;

   // Output word layout
   localparam int WORD_BITS = 16;
   localparam int DATA_BITS = 12;
   localparam int ZERO_BITS = WORD_BITS - DATA_BITS;

   // Edge counts within a frame, counted from the select fall
   localparam int       CNT_W       = 5;
   localparam logic [4:0] FALL_LAST  = 5'h10;  // 16th falling edge
   localparam logic [4:0] FALL_MODE  = 5'h0a;  // 10th falling edge
   localparam logic [4:0] FALL_NOISE = 5'h02;  // 2nd falling edge
   localparam logic [4:0] RISE_TRACK = 5'h0d;  // 13th rising edge

   // Acquisition interval measured against the system clock
   localparam int CLK_PERIOD_NS = 8;
   localparam int ACQ_NS        = 350;
   localparam int ACQ_CYCLES    = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACQ_W         = 6;

   // Reset values
   localparam logic RESET_OE_N   = 1'b1;
   localparam logic RESET_HOLD   = 1'b0;
   localparam logic RESET_NORMAL = 1'b0;

   // Frame sequencer states
   typedef enum logic [1:0] {
      SAFC_IDLE,
      SAFC_FRAME,
      SAFC_DONE
   } safc_state_t;

endpackage

// [hw/safc_sync.sv]
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module safc_sync
   import safc_pkg::*;
#(
   parameter int W = 1
)(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta;

   // First stage is read only by the second stage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta     <= '1;
         sync_out <= '1;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule

// [hw/safc_shifter.sv]
// Parallel-load, MSB-first output shift register
`timescale 1ns/100ps
module safc_shifter
   import safc_pkg::*;
#(
   parameter int W = WORD_BITS
)(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         load,
   input  wire logic [W-1:0] load_word,
   input  wire logic         shift,
   output logic              bit_out
);

   logic [W-1:0] word;

   // A one-bit word has nothing to shift; stop at elaboration
   if (W < 2) $error("safc_shifter: W must be at least 2");

   // Load wins over shift; zeros fill from the bottom
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         word <= '0;
      end else if (load) begin
         word <= load_word;
      end else if (shift) begin
         word <= {word[W-2:0], 1'b0};
      end
   end

   assign bit_out = word[W-1];

endmodule

// [bench/safc_host.sv]
// Behavioural host that frames conversions and captures the serial word
`timescale 1ns/100ps
module safc_host (
   input  wire logic clk,
   input  wire logic line,
   input  wire logic result_oe_n,
   input  wire logic hold_mode,
   output logic      conv_sel_n,
   output logic      serial_clk
);
   // Clock stands high and select inactive between frames
   initial begin
      conv_sel_n = 1'b1;
      serial_clk = 1'b1;
   end

   // Pins only move at rising edges of the system clock
   task automatic ticks(input int n);
      repeat (n) @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // One frame of 80 ns clock cycles, select raised after the last rise;
   // snap holds oe_n at rise 1, hold at rises 13 and 14, oe_n at rise 16
   // Frame length chosen by caller
   task automatic frame(input int falls, output logic [15:0] word,
                        output logic [3:0] snap);
      word = 16'h0000;
      snap = 4'h0;
      // Select falls with the clock high, no extra zero
      @(posedge clk);
      conv_sel_n <= 1'b0;
      ticks(5);
      for (int i = 1; i <= falls; i++) begin
         // Device launches on the fall, host takes at the rise
         serial_clk <= 1'b0;
         ticks(5);
         serial_clk <= 1'b1;
         // Captured bits gathered MSB first into the word
         word = {word[14:0], line};
         if (i == 1) snap[3] = result_oe_n;
         if (i == 13) snap[2] = hold_mode;
         if (i == 14) snap[1] = hold_mode;
         if (i == 16) snap[0] = result_oe_n;
         ticks(5);
      end
      conv_sel_n <= 1'b1;
      ticks(6);
   endtask
endmodule

// [bench/tb.sv]
// Self-checking bench for the frame control block
`timescale 1ns/100ps
module tb;
   import safc_pkg::*;
   logic        clk;
   logic        rst_n;
   logic [11:0] conv_result;
   logic        conv_sel_n, serial_clk, line, toggle;
   logic        result_serial_out, result_oe_n, hold_mode;
   logic        normal_mode, result_invalid, acq_short;
   int          n_fail, comparisons, seed;
   logic        mode, first;
   logic [15:0] word;
   logic [3:0]  snap;
   int          falls_tab [15] = '{16, 16, 12, 16, 16, 5, 1, 16, 9, 1,
                                   14, 10, 2, 16, 16};

   safc_frame_ctrl DUT (
      .clk               (clk),
      .rst_n             (rst_n),
      .conv_sel_n        (conv_sel_n),
      .serial_clk        (serial_clk),
      .conv_result       (conv_result),
      .result_serial_out (result_serial_out),
      .result_oe_n       (result_oe_n),
      .hold_mode         (hold_mode),
      .normal_mode       (normal_mode),
      .result_invalid    (result_invalid),
      .acq_short         (acq_short)
   );

   safc_host host (
      .clk         (clk),
      .line        (line),
      .result_oe_n (result_oe_n),
      .hold_mode   (hold_mode),
      .conv_sel_n  (conv_sel_n),
      .serial_clk  (serial_clk)
   );

   // Released data line wanders so a stale bit cannot pass as data
   assign line = result_oe_n ? toggle : result_serial_out;

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial toggle = 1'b0;
   always @(posedge clk) toggle <= ~toggle;

   ////////////////////////////////////////////////////////////////////////
   // Mode left behind by a frame ended after f falls
   function automatic logic next_mode(input logic m, input int f);
      if (f >= 10) return 1'b1;
      if (f >= 2) return 1'b0;
      return m;
   endfunction

   task automatic check(input string name, input logic [15:0] seen,
                        input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic complete_run;
      if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // One frame with its checks; gap is idle cycles after it
   task automatic run_frame(input int f, input int gap, input logic [11:0] d);
      logic inv;
      inv = first | ~mode;
      conv_result <= d;
      host.frame(f, word, snap);
      check("oe_n at rise 1", {15'h0, snap[3]}, 16'h0);
      if (f >= 14)
         check("hold at rise 13 14", {14'h0, snap[2:1]}, 16'h2);
      if (f == 16) begin
         check("oe_n at rise 16", {15'h0, snap[0]}, 16'h1);
         if (!inv)
            check("word", {1'b0, word[15:1]}, {4'h0, d});
      end
      check("oe_n after", {15'h0, result_oe_n}, 16'h1);
      check("hold after", {15'h0, hold_mode}, 16'h0);
      check("mode", {15'h0, normal_mode}, {15'h0, next_mode(mode, f)});
      check("invalid", {15'h0, result_invalid}, {15'h0, inv});
      mode = next_mode(mode, f);
      first = 1'b0;
      host.ticks(gap);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Hard cut if a frame never finishes
   initial begin
      repeat (30000) @(posedge clk);
      n_fail++;
      complete_run();
   end

   initial begin
      seed = 32'h254d;
      n_fail = 0;
      comparisons = 0;
      mode = 1'b0;
      first = 1'b1;
      rst_n = 1'b0;
      conv_result = 12'h000;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check("reset outputs", {10'h0, result_serial_out,
            result_oe_n, hold_mode, normal_mode, result_invalid,
            acq_short}, 16'h0012);
      // Corner frames: aborts at every mode boundary, edge codes
      for (int i = 0; i < 15; i++) begin
         run_frame(falls_tab[i], (i == 3) ? 1 : 20,
                   (i == 1) ? 12'hfff : (i == 3) ? 12'h000 :
                   (i == 4) ? 12'h001 : 12'($random(seed)));
         if (i == 4)
            check("acq short", {15'h0, acq_short}, 16'h1);
         if (i == 5)
            check("acq long", {15'h0, acq_short}, 16'h0);
      end
      // Random frames, mostly full length
      for (int i = 0; i < 20; i++)
         run_frame(($random(seed) & 1) ? 16 : 1 + $unsigned($random(seed)) % 16,
                   12 + $unsigned($random(seed)) % 29, 12'($random(seed)));
      complete_run();
   end
endmodule
